// file: core/adcsc_core.sv
// Serial conversion sequencer: link engine, conversion timing, ready signalling
module adcsc_core
    import adcsc_pkg::*;
#(
    parameter int NCH = 8,
    parameter int DW = 24,
    parameter int TW = 16
)
(
    // Master clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic rdy_n,
    // Converter front end
    input wire logic [DW-1:0] sample,
    output logic chop_reverse,
    output logic [2:0] mux_ch,
    // Channel configuration
    input wire logic [NCH-1:0] ch_enable,
    input wire logic [NCH-1:0] chop_en,
    input wire logic [NCH-1:0][TW-1:0] conv_time
);
    localparam int SOW = CMD_W + DW;

    // Core-domain state
    logic [7:0] mode_reg;
    logic [7:0] io_reg;
    logic [NCH-1:0] ready;
    logic [NCH-1:0] next_ready;
    logic [DW-1:0] data_reg [NCH];
    logic [2:0] last_ch;
    adcsc_cstate_t cstate;
    logic [TW-1:0] cnt;
    logic [2:0] cur_ch;
    logic [DW-1:0] s_pos;
    logic [DW-1:0] s_neg;
    logic pend;
    logic [2:0] pend_ch;
    logic [DW-1:0] pend_data;
    logic single_ctx;
    // Link-domain state
    adcsc_lstate_t lstate;
    logic [5:0] bitcnt;
    logic [5:0] rd_len;
    logic [5:0] ones;
    logic [7:0] sh_in;
    logic [7:0] cmd;
    logic [SOW-1:0] sh_out;
    logic ld_full;
    logic ld_next;
    logic dump_rd;
    logic rd_dat;
    logic busy_l;
    logic wr_tgl;
    logic rd_tgl;
    logic srst_tgl;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;
    logic [2:0] rd_ch;
    // Crossings
    logic [3:0] ev_q;
    logic [3:0] ev_prev;
    logic [1:0] cfg_l;

    // Link events into the core, configuration bits back to the link
    adcsc_sync3 #(.W(4)) u_to_core (
        .clk(clk),
        .nrst(nrst),
        .d({wr_tgl, rd_tgl, srst_tgl, busy_l}),
        .q(ev_q)
    );
    adcsc_sync3 #(.W(2)) u_to_link (
        .clk(sclk),
        .nrst(nrst),
        .d({mode_reg[MODE_DUMP_BIT], mode_reg[MODE_CONTRD_BIT]}),
        .q(cfg_l)
    );

    // Link decode
    logic frame_rst_n;
    logic [7:0] next_in;
    logic cr_entry;
    logic dumpish;
    logic [5:0] next_len;
    logic link_rst;
    logic rd_go;
    logic wr_done;
    assign frame_rst_n = nrst & ~cs_n; // Chip select high parks the link
    assign next_in = {sh_in[6:0], din};
    assign cr_entry = (next_in == CR_ENTER_CMD) && cfg_l[0];
    assign dumpish = cfg_l[1] && (adcsc_is_data(next_in[5:0]) || adcsc_is_stat(next_in[5:0]));
    assign next_len = dumpish ? 6'(SOW) : adcsc_is_data(next_in[5:0]) ? 6'(DW) : 6'(CMD_W);
    assign link_rst = (ones == 6'(RESET_ONES - 1) && din)
        || (lstate == L_RD && dump_rd && din);
    assign wr_done = (lstate == L_WR) && (bitcnt == 6'h07);
    assign rd_go = (lstate == L_CMD && bitcnt == 6'h07 && next_in[CMD_READ_BIT] && !cr_entry
        && (adcsc_is_data(next_in[5:0]) || dumpish)) || (lstate == L_CR && bitcnt == 6'h00 && !din);

    // Framed command and transfer sequencing
    always_ff @(posedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            lstate <= L_CMD;
            bitcnt <= '0;
            sh_in <= '0;
            cmd <= '0;
            ones <= '0;
            rd_len <= '0;
            dump_rd <= 1'b0;
            rd_dat <= 1'b0;
            ld_full <= 1'b0;
            ld_next <= 1'b0;
        end
        else
        begin
            ones <= din ? ones + 6'h01 : 6'h00;
            sh_in <= next_in;
            ld_full <= 1'b0;
            ld_next <= 1'b0;
            if (link_rst)
            begin
                lstate <= L_CMD;
                bitcnt <= '0;
                ones <= '0;
                dump_rd <= 1'b0;
                rd_dat <= 1'b0;
            end
            else
            begin
                unique case (lstate)
                    L_CMD:
                    begin
                        if (bitcnt == 6'h07)
                        begin
                            bitcnt <= '0;
                            cmd <= next_in; // Command selects the next access
                            if (!next_in[CMD_READ_BIT])
                                lstate <= L_WR;
                            else if (cr_entry)
                                lstate <= L_CR;
                            else
                            begin
                                lstate <= L_RD;
                                rd_len <= next_len;
                                dump_rd <= dumpish;
                                rd_dat <= dumpish || adcsc_is_data(next_in[5:0]);
                                ld_full <= 1'b1;
                            end
                        end
                        else
                            bitcnt <= bitcnt + 6'h01;
                    end
                    L_WR:
                    begin
                        bitcnt <= (bitcnt == 6'h07) ? 6'h00 : bitcnt + 6'h01;
                        if (bitcnt == 6'h07)
                            lstate <= L_CMD;
                    end
                    L_RD:
                    begin
                        if (bitcnt == rd_len - 6'h01)
                        begin
                            lstate <= L_CMD;
                            bitcnt <= '0;
                            dump_rd <= 1'b0;
                            rd_dat <= 1'b0;
                        end
                        else
                            bitcnt <= bitcnt + 6'h01;
                    end
                    L_CR:
                    begin
                        // Any high bit leaves streaming and starts a fresh command
                        if (din)
                        begin
                            lstate <= L_CMD;
                            bitcnt <= 6'h01;
                        end
                        else
                        begin
                            ld_next <= (bitcnt == 6'h00);
                            bitcnt <= (bitcnt == 6'(SOW - 1)) ? 6'h00 : bitcnt + 6'h01;
                        end
                    end
                endcase
            end
        end
    end

    // Busy covers data reads so the core holds back commits
    always_ff @(posedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            busy_l <= 1'b0;
        else
            busy_l <= (lstate == L_RD && rd_dat) || (lstate == L_CR && bitcnt != 6'h00);
    end

    // Event toggles survive chip select, unlike the frame state
    always_ff @(posedge sclk or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_tgl <= 1'b0;
            rd_tgl <= 1'b0;
            srst_tgl <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            rd_ch <= '0;
        end
        else if (!cs_n)
        begin
            if (link_rst)
                srst_tgl <= ~srst_tgl;
            if (wr_done && !link_rst)
            begin
                wr_addr <= cmd[5:0];
                wr_data <= next_in;
                wr_tgl <= ~wr_tgl;
            end
            if (rd_go && !link_rst)
            begin
                rd_ch <= (lstate == L_CR) ? last_ch : next_in[2:0];
                rd_tgl <= ~rd_tgl;
            end
        end
    end

    // Outgoing word; core registers are stable while a data read is busy
    logic [2:0] snap_ch;
    logic [7:0] snap_stat;
    logic [SOW-1:0] snap;
    always_comb
    begin
        snap_ch = (lstate == L_CR) ? last_ch : cmd[2:0];
        snap_stat = '0;
        snap_stat[STAT_CH_LSB +: 3] = snap_ch;
        snap_stat[STAT_RDY_BIT] = ready[snap_ch];
        snap_stat[STAT_SIGN_BIT] = data_reg[snap_ch][DW-1];
        snap = '0;
        if (lstate == L_CR || dump_rd)
            snap = {snap_stat, data_reg[snap_ch]};
        else if (adcsc_is_data(cmd[5:0]))
            snap = {data_reg[snap_ch], 8'h00};
        else if (adcsc_is_stat(cmd[5:0]))
            snap = {snap_stat, {DW{1'b0}}};
        else if (cmd[5:3] == ADDR_MODE[5:3])
            snap = {mode_reg, {DW{1'b0}}};
        else if (cmd[5:0] == ADDR_IO)
            snap = {io_reg, {DW{1'b0}}};
    end

    // Data out changes on the falling edge for the host's rising-edge sample
    always_ff @(negedge sclk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            sh_out <= '0;
        else if (ld_full)
            sh_out <= snap;
        else if (ld_next)
            sh_out <= {snap[SOW-2:0], 1'b0};
        else
            sh_out <= {sh_out[SOW-2:0], 1'b0};
    end
    // Idle streaming shows the live word until the first edge of an access
    assign dout = (lstate == L_CR && bitcnt == 6'h00) ? snap[SOW-1] : sh_out[SOW-1];
    assign dout_oe = ~cs_n;

    // Core-side events from the settled toggles
    logic wr_evt;
    logic rd_evt;
    logic srst_evt;
    logic busy_s;
    logic mode_wr;
    logic start;
    logic cal;
    logic done;
    logic scale_start;
    logic [2:0] new_mode;
    logic [DW:0] diff;
    logic [DW-1:0] result;
    assign wr_evt = ev_q[3] ^ ev_prev[3];
    assign rd_evt = ev_q[2] ^ ev_prev[2];
    assign srst_evt = ev_q[1] ^ ev_prev[1];
    assign busy_s = ev_q[0];
    assign mode_wr = wr_evt && (wr_addr[5:3] == ADDR_MODE[5:3]);
    assign new_mode = wr_data[MODE_HI:MODE_LO];
    assign start = mode_wr && new_mode != MODE_IDLE && new_mode != MODE_STANDBY;
    assign cal = mode_reg[MODE_HI - MODE_CAL_BIT + MODE_LO - MODE_LO + MODE_CAL_BIT];
    assign done = (cstate == C_SCALE) && (cnt == '0);
    assign scale_start = (cnt == '0) && ((cstate == C_SMP1 && !chop_en[cur_ch])
        || cstate == C_SMP2);
    // Direct minus reversed halves cancels the offset term
    assign diff = {s_pos[DW-1], s_pos} - {s_neg[DW-1], s_neg};
    assign result = chop_en[cur_ch] ? diff[DW:1] : s_pos;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ev_prev <= '0;
        else
            ev_prev <= ev_q;
    end

    // Mode and port registers; a finished one-shot returns to idle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_reg <= MODE_RST;
            io_reg <= IO_RST;
        end
        else if (srst_evt)
        begin
            mode_reg <= MODE_RST;
            io_reg <= IO_RST;
        end
        else
        begin
            if (mode_wr)
                mode_reg <= wr_data; // This write sets or clears continuous read; a serial reset clears it
            else if (done && mode_reg[MODE_HI:MODE_LO] != MODE_CONT)
                mode_reg[MODE_HI:MODE_LO] <= MODE_IDLE;
            if (wr_evt && wr_addr == ADDR_IO)
                io_reg <= wr_data;
        end
    end

    // Next enabled channel after c, c itself when none other is on
    function automatic logic [2:0] next_en(input logic [2:0] c, input logic [NCH-1:0] en);
        int k;
        next_en = c;
        for (int i = NCH - 1; i >= 1; i--)
        begin
            k = (int'(c) + i) % NCH;
            if (en[k])
                next_en = 3'(k);
        end
    endfunction : next_en

    // Conversion timing: settle, sample, optional reversed pass, scale
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cstate <= C_IDLE;
            cnt <= '0;
            cur_ch <= '0;
            s_pos <= '0;
            s_neg <= '0;
            chop_reverse <= 1'b0;
        end
        else if (srst_evt || (mode_wr && !start))
        begin
            cstate <= C_IDLE;
            chop_reverse <= 1'b0;
        end
        else if (start)
        begin
            cstate <= C_SET1;
            cnt <= TW'(SETTLE_FIRST_CYC - 1);
            cur_ch <= wr_addr[2:0]; // Channel from the mode register address
            chop_reverse <= 1'b0;
        end
        else
        begin
            cnt <= cnt - 1'b1;
            unique case (cstate)
                C_IDLE: cnt <= '0;
                C_SET1, C_SET2:
                    if (cnt == '0)
                    begin
                        cstate <= (cstate == C_SET1) ? C_SMP1 : C_SMP2;
                        cnt <= conv_time[cur_ch] - 1'b1;
                    end
                C_SMP1:
                    if (cnt == '0)
                    begin
                        s_pos <= sample;
                        cstate <= chop_en[cur_ch] ? C_SET2 : C_SCALE;
                        cnt <= chop_en[cur_ch] ? TW'(SETTLE_CHOP_CYC - 1) : TW'(SCALE_CYC - 1);
                        chop_reverse <= chop_en[cur_ch];
                    end
                C_SMP2:
                    if (cnt == '0)
                    begin
                        s_neg <= sample;
                        chop_reverse <= 1'b0;
                        cstate <= C_SCALE;
                        cnt <= TW'(SCALE_CYC - 1);
                    end
                C_SCALE:
                    if (cnt == '0)
                    begin
                        // Back-to-back passes make the scan the sum of times
                        if (mode_reg[MODE_HI:MODE_LO] == MODE_CONT)
                        begin
                            cstate <= C_SET1;
                            cnt <= TW'(SETTLE_FIRST_CYC - 1);
                            cur_ch <= next_en(cur_ch, ch_enable);
                        end
                        else
                            cstate <= C_IDLE;
                    end
            endcase
        end
    end
    assign mux_ch = cur_ch;

    // Result commit, deferred while a data read is busy
    logic c_valid;
    logic [2:0] c_ch;
    logic [DW-1:0] c_data;
    always_comb
    begin
        c_valid = 1'b0;
        c_ch = pend_ch;
        c_data = pend_data;
        if (done && !cal && !busy_s)
        begin
            c_valid = 1'b1;
            c_ch = cur_ch;
            c_data = result;
        end
        else if (pend && !busy_s)
            c_valid = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pend <= 1'b0;
            pend_ch <= '0;
            pend_data <= '0;
        end
        else if (srst_evt)
            pend <= 1'b0;
        else if (done && !cal && busy_s)
        begin
            pend <= (rd_ch != cur_ch); // Dropped when it targets the register under read
            pend_ch <= cur_ch;
            pend_data <= result;
        end
        else if (pend && (!busy_s || (rd_evt && rd_ch == pend_ch)))
            pend <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NCH; i++)
                data_reg[i] <= '0;
            last_ch <= '0;
        end
        else if (c_valid)
        begin
            data_reg[c_ch] <= c_data; // Unread data is overwritten
            last_ch <= c_ch;
        end
    end

    // Ready bits: a result that lands in the clearing cycle wins
    always_comb
    begin
        next_ready = ready;
        if (mode_wr)
            next_ready = '0;
        if (scale_start && !cal)
            next_ready[cur_ch] = 1'b0;
        if (rd_evt)
            next_ready[rd_ch] = 1'b0;
        if (c_valid)
            next_ready[c_ch] = 1'b1;
        if (done && cal)
            next_ready = '1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ready <= '0;
        else if (srst_evt)
            ready <= '0;
        else
            ready <= next_ready;
    end

    // Ready pin
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdy_n <= 1'b1;
            single_ctx <= 1'b0;
        end
        else if (srst_evt)
        begin
            rdy_n <= 1'b1;
            single_ctx <= 1'b0;
        end
        else if (mode_wr)
        begin
            rdy_n <= 1'b1;
            single_ctx <= (new_mode != MODE_CONT);
        end
        else if ((single_ctx && c_valid) || (done && cal))
            rdy_n <= 1'b0;
        else if (cstate == C_SCALE)
            rdy_n <= 1'b1; // High through every scaling time
        else if (single_ctx)
        begin
            if (rd_evt)
                rdy_n <= 1'b1;
        end
        else if (io_reg[IO_READY_PIN_FUNCTION_BIT])
            rdy_n <= !((&(next_ready | ~ch_enable)) && (|ch_enable));
        else
            rdy_n <= !(|next_ready);
    end
endmodule : adcsc_core

// file: core/adcsc_pkg.sv
// Constants, types and helpers of the serial conversion sequencer
package adcsc_pkg;
    // Command byte
    localparam int CMD_W = 8;
    localparam int CMD_READ_BIT = 6;
    localparam logic [7:0] CR_ENTER_CMD = 8'h48;
    // Register addresses, channel in the low three bits of the data, status and mode addresses
    localparam logic [5:0] ADDR_IO = 6'h01;
    localparam logic [5:0] ADDR_DATA = 6'h08;
    localparam logic [5:0] ADDR_STAT = 6'h20;
    localparam logic [5:0] ADDR_MODE = 6'h38;
    // Mode register layout and codes
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 5;
    localparam int MODE_DUMP_BIT = 3;
    localparam int MODE_CONTRD_BIT = 1;
    localparam int MODE_CAL_BIT = 2;
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_CONT = 3'h1;
    localparam logic [2:0] MODE_SINGLE = 3'h2;
    localparam logic [2:0] MODE_STANDBY = 3'h3;
    localparam logic [7:0] MODE_RST = 8'h00;
    // Port register layout
    localparam int IO_READY_PIN_FUNCTION_BIT = 0;
    localparam logic [7:0] IO_RST = 8'h00;
    // Channel status byte layout
    localparam int STAT_CH_LSB = 5;
    localparam int STAT_RDY_BIT = 3;
    localparam int STAT_SIGN_BIT = 0;
    // Conversion timing in master clock cycles
    localparam int SETTLE_FIRST_CYC = 43;
    localparam int SETTLE_CHOP_CYC = 42;
    localparam int SCALE_CYC = 163;
    // Serial reset sequence length
    localparam int RESET_ONES = 32;

    typedef enum logic [2:0] {C_IDLE, C_SET1, C_SMP1, C_SET2, C_SMP2, C_SCALE} adcsc_cstate_t;
    typedef enum logic [1:0] {L_CMD, L_WR, L_RD, L_CR} adcsc_lstate_t;

    function automatic logic adcsc_is_data(input logic [5:0] a);
        return a[5:3] == ADDR_DATA[5:3];
    endfunction : adcsc_is_data

    function automatic logic adcsc_is_stat(input logic [5:0] a);
        return a[5:3] == ADDR_STAT[5:3];
    endfunction : adcsc_is_stat
endpackage : adcsc_pkg

// file: core/adcsc_sync3.sv
// Three-stage synchroniser that passes a bit once stages two and three agree
module adcsc_sync3
#(
    parameter int W = 1
)
(
    // Destination clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Source levels and settled copy
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // Stage one feeds only stage two
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q <= '0;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= (s2 & s3) | (q & (s2 ^ s3)); // Hold while stages disagree
        end
    end
endmodule : adcsc_sync3

// file: tb/adcsc_assertions.sv
// Pin-level assertions of the conversion sequencer
module adcsc_assertions
    import adcsc_pkg::*;
#(
    parameter int NCH = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Watched pins
    input wire logic cs_n,
    input wire logic dout_oe,
    input wire logic rdy_n,
    input wire logic chop_reverse,
    input wire logic [2:0] mux_ch,
    input wire logic [NCH-1:0] chop_en
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Output floats while deselected
    a_oe_tracks_cs: assert property (dout_oe == !cs_n)
        else $error("dout_oe wrong");
    a_rev_needs_chop: assert property (chop_reverse |-> chop_en[mux_ch])
        else $error("reverse without chop");
    // Reversed pass stays high for at least eight cycles after it rises
    a_rev_min_run: assert property ($rose(chop_reverse) |=> chop_reverse[*8])
        else $error("reverse too short");
    a_rev_same_ch: assert property ($rose(chop_reverse) |-> mux_ch == $past(mux_ch, 40))
        else $error("reverse on other channel");
    a_rev_mux_hold: assert property (chop_reverse && $past(chop_reverse) |-> $stable(mux_ch))
        else $error("channel moved");
    // Scaling follows the reversed pass with the pin high
    a_scale_rdy_high: assert property ($fell(chop_reverse) |=> rdy_n[*8])
        else $error("rdy_n low in scaling");
    a_rdy_fall_gap: assert property ($fell(rdy_n) |-> $past(rdy_n, 150))
        else $error("rdy_n high too short");
    a_rdy_after_scale: assert property ($fell(rdy_n) |-> !$past(chop_reverse, 100))
        else $error("rdy_n fell early");
endmodule : adcsc_assertions

// file: tb/adcsc_host.sv
// Host serial controller model
module adcsc_host
(
    // Driven by the host
    output logic sclk,
    output logic cs_n,
    output logic din,
    // Driven by the device
    input wire logic dout,
    input wire logic dout_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // Clock parked high between frames
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // One frame MSB first, 15 ns per bit
    task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = '0;
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--)
        begin
            #7.5 sclk = 1'b0;
            din = tx[i];
            #7.5 sclk = 1'b1;
            rx = {rx[62:0], dout_oe ? dout : ~rx[0]};
        end
        #7.5 cs_n = 1'b1;
        din = ~din; // No stale level once released
        // Deselected gap, so back-to-back frames never pulse chip select in one time step
        #15;
    endtask : xfer
endmodule : adcsc_host

// file: tb/tb_top.sv
// Top bench of the conversion sequencer
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; \
    $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_top
    import adcsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LAT = SETTLE_FIRST_CYC + 4 + SCALE_CYC;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sclk, cs_n, din, dout, dout_oe, rdy_n, chop_reverse;
    logic [2:0] mux_ch;
    logic [23:0] sample = 24'h000000;
    logic [7:0] ch_enable = 8'h01;
    logic [7:0] chop_en = 8'h00;
    logic [7:0][15:0] conv_time = {8{16'h0004}};
    logic [63:0] r;
    int c;
    int err_total = 0;
    int check_count = 0;
    initial
    begin
        forever #4 clk = ~clk;
    end
    // Reversed input reads as minus three times direct, so the average differs
    always @(posedge clk)
        sample <= chop_reverse ? 24'hFFD000 : 24'h001000;
    adcsc_host u_host (.sclk, .cs_n, .din, .dout, .dout_oe);
    adcsc_core u_dut (.clk, .nrst, .sclk, .cs_n, .din, .dout, .dout_oe, .rdy_n, .sample,
        .chop_reverse, .mux_ch, .ch_enable, .chop_en, .conv_time);
    task automatic x(input logic [63:0] t, input int n);
        u_host.xfer(t, n, r);
    endtask : x
    // Bounded wait for the ready pin
    task automatic wait_low();
        c = 0;
        while (rdy_n !== 1'b0 && c < 3000)
        begin
            @(negedge clk);
            c++;
        end
        `CHK("rdy_n", 1'b0, rdy_n)
    endtask : wait_low
    task automatic t_single();
        x(64'h3840, 16);
        wait_low();
        x(64'h3840, 16);
        repeat (8) @(negedge clk);
        `CHK("rdy_n", 1'b1, rdy_n)
        wait_low();
        `CHK("latency", 1'b1, c + 12 >= LAT && c <= LAT)
        x(64'h48000000, 32);
        `CHK("data", 24'h001000, r[23:0])
        repeat (8) @(negedge clk);
        `CHK("rdy_n", 1'b1, rdy_n)
        x(64'h7800, 16);
        `CHK("mode", 8'h00, r[7:0])
    endtask : t_single
    task automatic t_dump();
        @(posedge clk);
        chop_en <= 8'h02;
        x(64'h3948, 16);
        x(64'h4100, 16); // Spacer carries the dump bit over
        wait_low();
        x(64'h4900000000, 40);
        `CHK("dump", 32'h28002000, r[31:0])
    endtask : t_dump
    task automatic t_stream();
        @(posedge clk);
        ch_enable <= 8'h03;
        x(64'h3822, 16);
        x(64'h4100, 16);
        wait_low();
        repeat (2)
        begin
            x(64'h4800000000, 40);
            `CHK("stream ch", 3'h0, r[31:29])
            `CHK("stream data", 24'h001000, r[23:0])
            x(64'h80, 8);
        end
        x(64'h00FFFFFFFFFF, 48);
        repeat (10) @(negedge clk);
        `CHK("rdy_n", 1'b1, rdy_n)
        x(64'h7800, 16);
        `CHK("mode", 8'h00, r[7:0])
    endtask : t_stream
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        t_single();
        t_dump();
        t_stream();
        end_sim();
    end
    // Watchdog, several times the expected run
    initial
    begin
        #100us;
        err_total++;
        end_sim();
    end
endmodule : tb_top
bind adcsc_core adcsc_assertions #(.NCH(NCH)) u_chk (.clk, .nrst, .cs_n, .dout_oe, .rdy_n,
    .chop_reverse, .mux_ch, .chop_en);
